// ### core/asd_decode_trigger.sv
// serial audio decoder with data, window and word-select trigger, apb registers
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module asd_decode_trigger #(
    parameter int unsigned NUM_CH = asd_pkg::NCH
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // audio lines
    input wire logic i_bclk,
    input wire logic i_ws,
    input wire logic i_sdata,
    // register bus
    input wire asd_pkg::asd_apb_req_s i_apb,
    output var asd_pkg::asd_apb_rsp_s o_apb,
    // trigger
    output var logic o_trig_pulse
);
    import asd_pkg::*;

    if (NUM_CH < 2 || NUM_CH > NCH) begin : g_bad_param
        $error("NUM_CH must lie between 2 and 8");
    end

    //==============================================================
    // pin synchronisers, {bclk, ws, data}
    logic [2:0] s1_reg, s2_reg, s3_reg;
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            s1_reg <= 3'h0;
            s2_reg <= 3'h0;
            s3_reg <= 3'h0;
        end else begin
            s1_reg <= {i_bclk, i_ws, i_sdata};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    //==============================================================
    // configuration
    asd_ctrl_s ctrl_reg;
    asd_fmt_s fmt_reg;
    logic [15:0] win_reg;
    asd_op_e op_reg [NUM_CH];
    logic [31:0] min_reg [NUM_CH];
    logic [31:0] max_reg [NUM_CH];
    logic signed [31:0] word_reg [NUM_CH];

    wire logic is_tdm = (ctrl_reg.fmt == FMT_TDM);
    wire logic is_std = (ctrl_reg.fmt == FMT_STANDARD);
    wire logic ws_inv = ctrl_reg.ws_inv;
    wire logic data_low = ctrl_reg.data_low;
    // stereo halves have no fixed length, the word can span the full 32 bits
    wire logic [5:0] cl_eff = !is_tdm ? 6'd32 : (fmt_reg.chan_len == 6'd0) ? 6'd1 : // RULE12
                              (fmt_reg.chan_len > 6'd32) ? 6'd32 : fmt_reg.chan_len;
    wire logic [5:0] wl_eff = (fmt_reg.word_len == 6'd0) ? 6'd1 : // RULE15
                              (fmt_reg.word_len > cl_eff) ? cl_eff : fmt_reg.word_len;
    wire logic [5:0] off_max = cl_eff - wl_eff;
    wire logic [5:0] off_eff = (is_tdm && fmt_reg.offset > off_max) ? off_max : fmt_reg.offset; // RULE13 RULE14
    wire logic [3:0] cnt_eff = (fmt_reg.ch_count == 4'd0) ? 4'd1 : // RULE8 RULE10
                               (fmt_reg.ch_count > 4'(NUM_CH)) ? 4'(NUM_CH) : fmt_reg.ch_count;

    //==============================================================
    // bit sampling
    wire logic bclk_rise = s2_reg[2] & ~s3_reg[2];
    wire logic bclk_fall = ~s2_reg[2] & s3_reg[2];
    wire logic samp = ctrl_reg.sample_fall ? bclk_fall : bclk_rise; // RULE3
    wire logic data_raw = s2_reg[0];
    wire logic bit_in = data_raw ^ data_low; // RULE4
    wire logic ws_now = s2_reg[1];

    logic ws_last_reg, chg_d_reg, cur_ch_reg, seen_reg;
    logic [6:0] bitcnt_reg;
    logic [63:0] hist_reg;
    asd_tstate_e tst_reg;
    logic [5:0] pos_reg;
    logic [2:0] tch_reg;

    wire logic ws_chg = (ws_now != ws_last_reg);
    // standard framing sees its word boundary one bit after the select edge
    wire logic st_bound = is_std ? chg_d_reg : ws_chg; // RULE5
    wire logic fs_edge = ws_chg & (ws_now ^ ws_inv); // RULE2
    wire logic [63:0] hist_next = {hist_reg[62:0], bit_in};
    wire logic blk_now = fs_edge && fmt_reg.delay == 6'd0;
    wire logic blk_from_dly = !fs_edge && tst_reg == T_DELAY && pos_reg == fmt_reg.delay; // RULE11
    wire logic in_blk = blk_now || blk_from_dly || (!fs_edge && tst_reg == T_BLOCK);
    wire logic [5:0] blk_idx = (blk_now || blk_from_dly) ? 6'd0 : pos_reg;
    wire logic blk_end = in_blk && blk_idx == cl_eff - 6'd1; // RULE12
    wire logic [2:0] ch_now = fs_edge ? 3'd0 : tch_reg;
    wire logic tdm_last = blk_end && {1'b0, ch_now} == cnt_eff - 4'd1;
    wire logic [63:0] hist_tdm = (blk_idx == 6'd0) ? {63'h0, bit_in} : hist_next;

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ws_last_reg <= 1'b0;
            chg_d_reg <= 1'b0;
            cur_ch_reg <= 1'b0;
            seen_reg <= 1'b0;
            bitcnt_reg <= 7'd0;
            hist_reg <= 64'h0;
        end else if (samp) begin
            ws_last_reg <= ws_now;
            chg_d_reg <= ws_chg;
            if (is_tdm) begin
                hist_reg <= hist_tdm;
            end else if (st_bound) begin
                hist_reg <= {63'h0, bit_in};
                bitcnt_reg <= 7'd1;
                cur_ch_reg <= ws_now ^ ws_inv; // RULE1
                seen_reg <= 1'b1;
            end else begin
                hist_reg <= hist_next;
                bitcnt_reg <= (bitcnt_reg == 7'h7f) ? bitcnt_reg : bitcnt_reg + 7'd1;
            end
        end
    end

    //==============================================================
    // multiplexed frame walker
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            tst_reg <= T_IDLE;
            pos_reg <= 6'd0;
            tch_reg <= 3'd0;
        end else if (samp && is_tdm) begin
            if (fs_edge && !blk_now) begin
                tst_reg <= T_DELAY; // RULE11
                pos_reg <= 6'd1;
                tch_reg <= 3'd0;
            end else if (tdm_last) begin
                tst_reg <= T_IDLE;
            end else if (blk_end) begin
                tst_reg <= T_BLOCK;
                pos_reg <= 6'd0;
                tch_reg <= ch_now + 3'd1;
            end else if (in_blk) begin
                tst_reg <= T_BLOCK;
                pos_reg <= blk_idx + 6'd1;
                tch_reg <= ch_now;
            end else if (tst_reg == T_DELAY) begin
                pos_reg <= pos_reg + 6'd1;
            end
        end
    end

    //==============================================================
    // word extraction from the bit history
    function automatic logic [31:0] asd_rev(input logic [31:0] v);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 32; i++) begin
            r[i] = v[31 - i];
        end
        return r;
    endfunction

    wire logic [8:0] n9 = {2'b00, bitcnt_reg};
    wire logic [8:0] wl9 = {3'b000, wl_eff};
    wire logic [8:0] off9 = {3'b000, fmt_reg.offset};
    wire logic [8:0] sh_raw = (ctrl_reg.fmt == FMT_STANDARD) ? n9 - wl9 : // RULE5
                              (ctrl_reg.fmt == FMT_LEFT_ALIGNED) ? n9 - off9 - wl9 : // RULE6
                              (ctrl_reg.fmt == FMT_RIGHT_ALIGNED) ? off9 : // RULE7
                              {3'b000, cl_eff} - {3'b000, off_eff} - wl9; // RULE13
    wire logic [6:0] sh_amt = sh_raw[8] ? 7'd0 : sh_raw[6:0];
    wire logic [63:0] src = is_tdm ? hist_tdm : hist_reg;
    wire logic [63:0] src_sh = src >> sh_amt;
    wire logic [5:0] pad = 6'd32 - wl_eff;
    wire logic [31:0] msk = 32'hffff_ffff >> pad;
    wire logic [31:0] w_msb = src_sh[31:0] & msk; // RULE24
    wire logic [31:0] w_ord = ctrl_reg.lsb_first ? (asd_rev(src_sh[31:0]) >> pad) : w_msb; // RULE16
    wire logic signed [31:0] w_sext = $signed(w_ord << pad) >>> pad; // RULE19
    wire logic fin_valid = samp && (is_tdm ? blk_end : (st_bound && seen_reg));
    wire logic [2:0] fin_ch = is_tdm ? ch_now : {2'b00, cur_ch_reg};
    wire logic fin_last = is_tdm ? tdm_last : (cur_ch_reg != ctrl_reg.right_first); // RULE9

    logic frame_done_reg;
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            frame_done_reg <= 1'b0;
        end else begin
            frame_done_reg <= fin_valid && fin_last;
        end
    end

    //==============================================================
    // per-channel comparison
    logic [NUM_CH-1:0] act, cmp;
    for (genvar i = 0; i < NUM_CH; i++) begin : g_cmp
        wire logic signed [31:0] lo = $signed(min_reg[i] << pad) >>> pad; // RULE19
        wire logic signed [31:0] hi = $signed(max_reg[i] << pad) >>> pad;
        wire logic signed [31:0] w = word_reg[i];
        wire logic in_use = is_tdm ? (i < 32'(cnt_eff)) : (i < 2);
        assign act[i] = in_use && op_reg[i] != OP_DC; // RULE18
        assign cmp[i] = (op_reg[i] == OP_EQ) ? (w == lo) : // RULE17
                        (op_reg[i] == OP_NE) ? (w != lo) :
                        (op_reg[i] == OP_GT) ? (w > lo) :
                        (op_reg[i] == OP_LT) ? (w < lo) :
                        (op_reg[i] == OP_IN) ? (w >= lo && w <= hi) :
                        (op_reg[i] == OP_OUT) ? (w < lo || w > hi) : 1'b0;
    end
    wire logic all_ok = (&(~act | cmp)) && (|act);
    wire logic any_ok = |(act & cmp);
    wire logic cond = ctrl_reg.comb_or ? any_ok : all_ok; // RULE20

    //==============================================================
    // trigger selection
    logic [15:0] run_reg, trig_cnt_reg, frame_cnt_reg;
    wire logic [15:0] win_eff = (win_reg == 16'd0) ? 16'd1 : win_reg;
    wire logic win_hit = frame_done_reg && cond && (run_reg + 16'd1 >= win_eff); // RULE21
    wire logic ws_rise = s2_reg[1] & ~s3_reg[1];
    wire logic ws_fall = ~s2_reg[1] & s3_reg[1];
    wire logic ws_hit = ctrl_reg.ws_fall ? ws_fall : ws_rise; // RULE23
    wire logic hit = (ctrl_reg.ttype == TT_DATA) ? (frame_done_reg && cond) : // RULE22
                     (ctrl_reg.ttype == TT_WINDOW) ? win_hit :
                     (ctrl_reg.ttype == TT_WSEL) ? ws_hit : 1'b0;

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            run_reg <= 16'd0;
            o_trig_pulse <= 1'b0;
            trig_cnt_reg <= 16'd0;
            frame_cnt_reg <= 16'd0;
        end else begin
            o_trig_pulse <= ctrl_reg.trig_en && hit; // RULE25
            trig_cnt_reg <= trig_cnt_reg + 16'(ctrl_reg.trig_en && hit);
            frame_cnt_reg <= frame_cnt_reg + 16'(frame_done_reg);
            if (frame_done_reg) begin
                run_reg <= (cond && !win_hit) ? run_reg + 16'd1 : 16'd0; // RULE21
            end
        end
    end

    //==============================================================
    // apb slave: one wait state, answer in the second access cycle
    wire logic [2:0] reg_idx = i_apb.paddr[4:2];
    wire logic [2:0] region = i_apb.paddr[7:5];
    wire logic ch_ok = reg_idx <= 3'(NUM_CH - 1);
    wire logic acc = i_apb.psel & i_apb.penable;
    wire logic wr_en = acc & i_apb.pwrite & o_apb.pready;
    wire logic mapped = (region == OFF_CTRL[7:5]) ? (reg_idx <= OFF_STAT[4:2]) :
                        (region <= OFF_WORD[7:5]) ? ch_ok : 1'b0;
    wire logic [31:0] scal_data = (reg_idx == OFF_CTRL[4:2]) ? ctrl_reg :
                                  (reg_idx == OFF_FMT[4:2]) ? fmt_reg :
                                  (reg_idx == OFF_WIN[4:2]) ? {16'h0, win_reg} :
                                  (reg_idx == OFF_STAT[4:2]) ? {frame_cnt_reg, trig_cnt_reg} : 32'h0;
    wire logic [31:0] rd_data = !mapped ? 32'h0 :
                                (region == OFF_CTRL[7:5]) ? scal_data :
                                (region == OFF_OP[7:5]) ? {29'h0, op_reg[reg_idx]} :
                                (region == OFF_MIN[7:5]) ? min_reg[reg_idx] :
                                (region == OFF_MAX[7:5]) ? max_reg[reg_idx] : word_reg[reg_idx];

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_apb <= '0;
        end else begin
            o_apb.pready <= acc & ~o_apb.pready;
            o_apb.pslverr <= acc & ~o_apb.pready & ~mapped;
            o_apb.prdata <= (acc & ~o_apb.pready & ~i_apb.pwrite) ? rd_data : 32'h0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ctrl_reg <= asd_ctrl_s'(RST_CTRL);
            fmt_reg <= asd_fmt_s'(RST_FMT);
            win_reg <= RST_WIN;
        end else if (wr_en && mapped && region == OFF_CTRL[7:5]) begin
            if (reg_idx == OFF_CTRL[4:2]) begin
                ctrl_reg <= asd_ctrl_s'({20'h0, i_apb.pwdata[11:0]});
            end
            if (reg_idx == OFF_FMT[4:2]) begin
                fmt_reg <= asd_fmt_s'({4'h0, i_apb.pwdata[27:0]});
            end
            if (reg_idx == OFF_WIN[4:2]) begin
                win_reg <= i_apb.pwdata[15:0];
            end
        end
    end

    // decoded words live beside the channel limits; a word update and a bus write never hit the same array
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                op_reg[i] <= OP_DC;
                min_reg[i] <= 32'h0;
                max_reg[i] <= 32'h0;
                word_reg[i] <= 32'sh0;
            end
        end else begin
            if (fin_valid) begin
                word_reg[fin_ch] <= w_sext;
            end
            if (wr_en && mapped && region == OFF_OP[7:5]) begin
                op_reg[reg_idx] <= (i_apb.pwdata[2:0] > 3'h6) ? OP_DC : asd_op_e'(i_apb.pwdata[2:0]);
            end
            if (wr_en && mapped && region == OFF_MIN[7:5]) begin
                min_reg[reg_idx] <= i_apb.pwdata;
            end
            if (wr_en && mapped && region == OFF_MAX[7:5]) begin
                max_reg[reg_idx] <= i_apb.pwdata;
            end
        end
    end

    //==============================================================
    // assertions
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);

    property p_chan_map;
        samp && !is_tdm && !is_std && ws_chg |=> cur_ch_reg == ($past(ws_now) ^ $past(ws_inv));
    endproperty
    a_chan_map: assert property (p_chan_map) else $error("channel not mapped from word select"); // RULE1
    property p_tdm_start;
        samp && is_tdm && fs_edge && fmt_reg.delay != 6'd0 |=> tst_reg == T_DELAY && pos_reg == 6'd1;
    endproperty
    a_tdm_start: assert property (p_tdm_start) else $error("frame did not start at sync edge"); // RULE2
    property p_data_pol;
        samp && !is_tdm && !st_bound |=> hist_reg[0] == ($past(data_raw) ^ $past(data_low));
    endproperty
    a_data_pol: assert property (p_data_pol) else $error("sampled bit has wrong polarity"); // RULE4
    property p_clamp;
        is_tdm |-> {1'b0, off_eff} + {1'b0, wl_eff} <= {1'b0, cl_eff};
    endproperty
    a_clamp: assert property (p_clamp) else $error("offset plus word exceeds channel"); // RULE14
    property p_wlen;
        wl_eff >= 6'd1 && wl_eff <= cl_eff;
    endproperty
    a_wlen: assert property (p_wlen) else $error("word length out of range"); // RULE15
    property p_first_half;
        fin_valid && !is_tdm && cur_ch_reg == ctrl_reg.right_first |=> !frame_done_reg;
    endproperty
    a_first_half: assert property (p_first_half) else $error("frame ended on first channel"); // RULE9
    property p_data_fire;
        frame_done_reg && ctrl_reg.trig_en && ctrl_reg.ttype == TT_DATA && cond |=> o_trig_pulse;
    endproperty
    a_data_fire: assert property (p_data_fire) else $error("data trigger missed"); // RULE20
    property p_win_miss;
        ctrl_reg.ttype == TT_WINDOW && frame_done_reg && !cond |=> !o_trig_pulse ##1 run_reg == 16'd0;
    endproperty
    a_win_miss: assert property (p_win_miss) else $error("window run not restarted"); // RULE21
    property p_ws_fire;
        ctrl_reg.trig_en && ctrl_reg.ttype == TT_WSEL && ws_hit |=> o_trig_pulse;
    endproperty
    a_ws_fire: assert property (p_ws_fire) else $error("word select trigger missed"); // RULE23
    property p_err_quiet;
        ctrl_reg.ttype == TT_ERROR && $stable(ctrl_reg.ttype) |-> !o_trig_pulse;
    endproperty
    a_err_quiet: assert property (p_err_quiet) else $error("error type fired"); // RULE22
    property p_one_cycle;
        o_trig_pulse |=> !o_trig_pulse;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("trigger pulse longer than a cycle"); // RULE25

    c_tdm_frame: cover property (is_tdm && frame_done_reg);
    c_data_trig: cover property (ctrl_reg.ttype == TT_DATA && o_trig_pulse);
    c_win_trig: cover property (ctrl_reg.ttype == TT_WINDOW && o_trig_pulse);
    c_ws_trig: cover property (ctrl_reg.ttype == TT_WSEL && o_trig_pulse);
endmodule
`default_nettype wire

// ### core/asd_pkg.sv
// shared constants, register layout and types of the audio serial decode trigger
//==============================================================
// Notes on behaviour
// [RULE1] normal polarity: word select low is left
// [RULE2] multiplexed frame starts at selected sync edge
// [RULE3] data sampled on chosen bit-clock edge
// [RULE4] data polarity setting may invert levels
// [RULE5] standard: word begins one bit after edge
// [RULE6] left-aligned word starts at edge plus offset
// [RULE7] right-aligned word ends at trailing edge, offset
// [RULE8] up to eight channel blocks per frame
// [RULE9] setting picks left or right first
// [RULE10] setting gives channel blocks per frame
// [RULE11] multiplexed delay shifts all channel blocks
// [RULE12] setting gives bits per channel block
// [RULE13] channel offset skips bits before the word
// [RULE14] offset clamps when lengths change
// [RULE15] word length from one to channel length
// [RULE16] bit order msb or lsb first
// [RULE17] six comparison operators per channel
// [RULE18] dont-care channels left out of evaluation
// [RULE19] words and limits are signed, width-bounded
// [RULE20] and/or combine within one frame
// [RULE21] window fires after consecutive satisfying frames
// [RULE22] trigger type data, window, edge, error; the error type never fires a pulse
// [RULE23] word-select edge trigger, rising or falling
// [RULE24] channel bits beyond the word ignored
// [RULE25] one-cycle trigger pulse after detection
// [RULE26] transmitter keeps lines stable, clock slow
package asd_pkg;
    //==============================================================
    // sizes
    localparam int unsigned NCH = 8;
    localparam int unsigned WMAX = 32;
    //==============================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FMT = 8'h04;
    localparam logic [7:0] OFF_WIN = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam logic [7:0] OFF_OP = 8'h20;
    localparam logic [7:0] OFF_MIN = 8'h40;
    localparam logic [7:0] OFF_MAX = 8'h60;
    localparam logic [7:0] OFF_WORD = 8'h80;
    //==============================================================
    // modes
    typedef enum logic [1:0] {FMT_STANDARD = 2'h0, FMT_LEFT_ALIGNED = 2'h1,
                              FMT_RIGHT_ALIGNED = 2'h2, FMT_TDM = 2'h3} asd_format_e;
    typedef enum logic [1:0] {TT_DATA = 2'h0, TT_WINDOW = 2'h1, TT_WSEL = 2'h2, TT_ERROR = 2'h3} asd_ttype_e;
    typedef enum logic [2:0] {OP_DC = 3'h0, OP_EQ = 3'h1, OP_NE = 3'h2, OP_GT = 3'h3,
                              OP_LT = 3'h4, OP_IN = 3'h5, OP_OUT = 3'h6} asd_op_e;
    typedef enum logic [2:0] {T_IDLE = 3'b001, T_DELAY = 3'b010, T_BLOCK = 3'b100} asd_tstate_e;
    //==============================================================
    // register layouts, msb first
    typedef struct packed {
        logic [19:0] rsvd;
        logic ws_fall;
        logic comb_or;
        asd_ttype_e ttype;
        logic trig_en;
        logic lsb_first;
        logic right_first;
        logic data_low;
        logic sample_fall;
        logic ws_inv;
        asd_format_e fmt;
    } asd_ctrl_s;
    typedef struct packed {
        logic [3:0] rsvd;
        logic [3:0] ch_count;
        logic [5:0] delay;
        logic [5:0] offset;
        logic [5:0] chan_len;
        logic [5:0] word_len;
    } asd_fmt_s;
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_FMT = 32'h0800_0820;
    localparam logic [15:0] RST_WIN = 16'h0001;
    //==============================================================
    // bus carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } asd_apb_req_s;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } asd_apb_rsp_s;
endpackage

// ### testbench/asd_audio_tx.sv
// behavioural serial audio transmitter driving bit clock, word select and data
`timescale 1ns/1ps
`default_nettype none
module asd_audio_tx (
    // audio lines
    output var logic o_bclk,
    output var logic o_ws,
    output var logic o_sdata
);
    initial begin
        o_bclk = 1'b0;
        o_ws = 1'b0;
        o_sdata = 1'b0;
    end
    //==============================================================
    // standard framing, 32 bit clocks per channel, msb first
    task automatic send(input int frames, input logic [31:0] lw, input logic [31:0] rw, input int wl,
                        input logic inv);
        logic [31:0] w;
        for (int f = 0; f < frames; f++) begin
            for (int ch = 0; ch < 2; ch++) begin
                w = ch[0] ? rw : lw;
                for (int b = 0; b < 32; b++) begin
                    // lines change only while the bit clock is low
                    o_ws <= ch[0] ^ inv;
                    // tail bits toggle so a decoder that reads past the word is caught
                    o_sdata <= (b >= 1 && b <= wl) ? w[wl - b] : b[0];
                    #62.5 o_bclk <= 1'b1;
                    #62.5 o_bclk <= 1'b0;
                end
            end
        end
        // clock stands still between bursts, data no longer holds its last level
        o_sdata <= ~o_sdata;
    endtask
    //==============================================================
    // multiplexed framing: one-bit sync pulse that also serves as the one-bit delay, then two 8-bit blocks
    task automatic send_tdm(input int frames, input logic [15:0] d);
        for (int f = 0; f < frames; f++) begin
            for (int b = 0; b < 17; b++) begin
                o_ws <= (b == 0);
                o_sdata <= (b == 0) ? 1'b1 : d[16 - b];
                #62.5 o_bclk <= 1'b1;
                #62.5 o_bclk <= 1'b0;
            end
        end
        o_sdata <= ~o_sdata;
    endtask
endmodule
`default_nettype wire

// ### testbench/test_asd_decode_trigger.sv
// self-checking bench: registers over apb, stereo and multiplexed decode, triggers
`timescale 1ns/1ps
`default_nettype none
module test_asd_decode_trigger;
    import asd_pkg::*;
    logic i_mclk = 1'b0;
    logic i_reset_n = 1'b0;
    wire logic bclk, ws, sdata;
    asd_apb_req_s apb_req = '0;
    asd_apb_rsp_s o_apb;
    logic o_trig_pulse;
    int miscompares = 0;
    int cmp_count = 0;
    int pulses = 0;
    logic [31:0] q;
    logic e;
    always #5 i_mclk = ~i_mclk;
    asd_audio_tx tx (.o_bclk(bclk), .o_ws(ws), .o_sdata(sdata));
    asd_decode_trigger #(.NUM_CH(8)) DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_bclk(bclk), .i_ws(ws),
        .i_sdata(sdata), .i_apb(apb_req), .o_apb(o_apb), .o_trig_pulse(o_trig_pulse));
    always @(posedge i_mclk) if (o_trig_pulse === 1'b1) pulses <= pulses + 1;
    //==============================================================
    // helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // request held until the edge where pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge i_mclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_apb.pready !== 1'b1 && n < 100);
        // answer taken and request released at the very edge that sees pready
        q = o_apb.prdata;
        e = o_apb.pslverr;
        apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        if (n >= 100) miscompares++;
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    //==============================================================
    // scenarios
    task automatic t_reset_values();
        apb(1'b0, OFF_CTRL, '0); check("ctrl", q, RST_CTRL);
        apb(1'b0, OFF_FMT, '0); check("fmt", q, RST_FMT);
        apb(1'b0, OFF_WIN, '0); check("win", q, {16'h0000, RST_WIN});
        apb(1'b0, 8'h10, '0); check("unmapped", {e, q[30:0]}, 32'h8000_0000);
    endtask
    task automatic t_decode();
        // 8 bit words in 32 bit channels, both word-select polarities
        apb(1'b1, OFF_FMT, 32'h0800_0808);
        for (int inv = 0; inv < 2; inv++) begin
            apb(1'b1, OFF_CTRL, {29'h0, inv[0], 2'h0});
            tx.send(3, 32'h5a, 32'h81, 8, inv[0]);
            apb(1'b0, OFF_WORD, '0); check("left word", q, 32'h0000_005a);
            apb(1'b0, OFF_WORD + 8'h04, '0); check("right word", q, 32'hffff_ff81);
        end
    endtask
    task automatic t_trigger();
        int base;
        apb(1'b1, OFF_CTRL, 32'h0000_0080);
        apb(1'b1, OFF_OP, 32'h4);
        apb(1'b1, OFF_MIN, 32'h5a);
        base = pulses;
        tx.send(3, 32'h5a, 32'h81, 8, 1'b0);
        check("no pulse on less", 32'(pulses - base), 32'h0);
        apb(1'b1, OFF_OP, 32'h3);
        apb(1'b1, OFF_MIN, 32'h80);
        base = pulses;
        tx.send(3, 32'h5a, 32'h81, 8, 1'b0);
        // three frames complete in this burst and all satisfy the condition
        check("pulse on greater", 32'(pulses - base), 32'h3);
        apb(1'b0, OFF_STAT, '0); check("trigger count", q[15:0], 16'h0003);
        check("frame count", q[31:16], 16'd11);
    endtask
    task automatic t_modes();
        int base;
        // left-aligned with a one-bit offset, rising word-select edge as trigger
        apb(1'b1, OFF_FMT, 32'h0800_1808);
        apb(1'b1, OFF_CTRL, 32'h0000_0281);
        base = pulses;
        tx.send(3, 32'h3c, 32'hc3, 8, 1'b0);
        check("ws rises", 32'(pulses - base), 32'h3);
        apb(1'b0, OFF_WORD, '0); check("aligned left", q, 32'h0000_003c);
        apb(1'b0, OFF_WORD + 8'h04, '0); check("aligned right", q, 32'hffff_ffc3);
        // two blocks of 8 bits after a one-bit delay
        apb(1'b1, OFF_CTRL, 32'h0000_0003);
        apb(1'b1, OFF_FMT, 32'h0204_0208);
        tx.send_tdm(3, 16'h7196);
        apb(1'b0, OFF_WORD, '0); check("block 0", q, 32'h0000_0071);
        apb(1'b0, OFF_WORD + 8'h04, '0); check("block 1", q, 32'hffff_ff96);
    endtask
    initial begin
        repeat (10) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        t_reset_values();
        t_decode();
        t_trigger();
        t_modes();
        stop_test();
    end
    initial begin
        #400us;
        miscompares++;
        stop_test();
    end
endmodule
`default_nettype wire
